// [hdl/mie_pkg.sv]
package mie_pkg;

   // Bus widths
   localparam int INSTR_W = 14;
   localparam int PC_W    = 15;
   localparam int FADDR_W = 7;
   localparam int DATA_W  = 8;
   localparam int LATCH_W = 7;

   // Instruction field positions
   localparam int DEST_BIT  = 7;
   localparam int K11_MSB   = 10;
   localparam int K8_MSB    = 7;
   localparam int LATCH_MSB = 6;
   localparam int LATCH_LSB = 3;

   // Opcode patterns, don't-care bits as '?'
   localparam logic [13:0] PAT_CLEAR_W  = 14'b00_0001_0???_????;
   localparam logic [13:0] PAT_DEC_SKIP = 14'b00_1011_????_????;
   localparam logic [13:0] PAT_INC_SKIP = 14'b00_1111_????_????;
   localparam logic [13:0] PAT_INC_FILE = 14'b00_1010_????_????;
   localparam logic [13:0] PAT_BRANCH   = 14'b10_1???_????_????;
   localparam logic [13:0] PAT_OR_LIT   = 14'b11_1000_????_????;

   // Reset values
   localparam logic [13:0] NOP_WORD = 14'h0000;
   localparam logic [14:0] PC_RST   = 15'h0000;
   localparam logic [7:0]  W_RST    = 8'h00;
   localparam logic        Z_RST    = 1'b0;

   typedef enum logic [2:0] {
      no_operation_op,
      clear_working_reg_op,
      decrement_skip_zero_op,
      increment_skip_zero_op,
      increment_file_op,
      unconditional_branch_op,
      or_literal_working_op
   } mie_op_type;

   // One write towards the data register file
   typedef struct packed {
      logic                we;
      logic [FADDR_W-1:0]  addr;
      logic [DATA_W-1:0]   data;
   } mie_fwr_type;

   function automatic logic is_zero(input logic [DATA_W-1:0] v);
      return v == 8'h00;
   endfunction

endpackage

// [hdl/mie_alu.sv]
`timescale 1ns/100ps
module mie_alu (
   // Instruction and operands
   input  wire logic [mie_pkg::INSTR_W-1:0] instr,
   input  wire logic [mie_pkg::DATA_W-1:0]  w_data,
   input  wire logic [mie_pkg::DATA_W-1:0]  f_data,
   // Decoded result
   output mie_pkg::mie_op_type              op,
   output logic [mie_pkg::DATA_W-1:0]       res,
   output logic                             wr_w,
   output logic                             wr_f,
   output logic                             z_upd,
   output logic                             skip,
   output logic                             branch
);

   logic dest;

   always_comb begin
      casez (instr)
         mie_pkg::PAT_CLEAR_W:  op = mie_pkg::clear_working_reg_op;
         mie_pkg::PAT_DEC_SKIP: op = mie_pkg::decrement_skip_zero_op;
         mie_pkg::PAT_INC_SKIP: op = mie_pkg::increment_skip_zero_op;
         mie_pkg::PAT_INC_FILE: op = mie_pkg::increment_file_op;
         mie_pkg::PAT_BRANCH:   op = mie_pkg::unconditional_branch_op;
         mie_pkg::PAT_OR_LIT:   op = mie_pkg::or_literal_working_op;
         // Opcodes outside this subset run as a no-operation
         default:             op = mie_pkg::no_operation_op;
      endcase
   end

   always_comb begin
      dest   = instr[mie_pkg::DEST_BIT];
      res    = 8'h00;
      wr_w   = 1'b0;
      wr_f   = 1'b0;
      z_upd  = 1'b0;
      skip   = 1'b0;
      branch = 1'b0;
      unique case (op)
         mie_pkg::no_operation_op: begin
         end
         mie_pkg::clear_working_reg_op: begin
            res   = 8'h00;
            wr_w  = 1'b1;
            z_upd = 1'b1;
         end
         mie_pkg::decrement_skip_zero_op: begin
            res  = f_data - 8'h01;
            wr_w = !dest;
            wr_f = dest;
            skip = mie_pkg::is_zero(res);
         end
         mie_pkg::increment_skip_zero_op: begin
            res  = f_data + 8'h01;
            wr_w = !dest;
            wr_f = dest;
            skip = mie_pkg::is_zero(res);
         end
         mie_pkg::increment_file_op: begin
            res   = f_data + 8'h01;
            wr_w  = !dest;
            wr_f  = dest;
            z_upd = 1'b1;
         end
         mie_pkg::unconditional_branch_op: begin
            branch = 1'b1;
         end
         mie_pkg::or_literal_working_op: begin
            res   = w_data | instr[mie_pkg::K8_MSB:0];
            wr_w  = 1'b1;
            z_upd = 1'b1;
         end
      endcase
   end

endmodule

// [hdl/mie_core.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
module mie_core (
   // Clock and reset
   input  wire logic                         sys_clk,
   input  wire logic                         rst_n,
   // Program memory
   output logic [mie_pkg::PC_W-1:0]          prog_addr,
   input  wire logic [mie_pkg::INSTR_W-1:0]  prog_data,
   // Data register file
   output logic [mie_pkg::FADDR_W-1:0]       file_raddr,
   input  wire logic [mie_pkg::DATA_W-1:0]   file_rdata,
   output mie_pkg::mie_fwr_type              file_wr,
   // Upper program counter source
   input  wire logic [mie_pkg::LATCH_W-1:0]  program_counter_high_latch,
   // Core state
   output logic [mie_pkg::DATA_W-1:0]        working_out,
   output logic                              zero_flag,
   output logic                              skip_cycle
);

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [mie_pkg::PC_W-1:0]     pc_reg;
   logic [mie_pkg::PC_W-1:0]     pc_next;
   logic [mie_pkg::INSTR_W-1:0]  instr_reg;
   logic [mie_pkg::INSTR_W-1:0]  instr_next;
   logic [mie_pkg::FADDR_W-1:0]  raddr_reg;
   logic [mie_pkg::FADDR_W-1:0]  raddr_next;
   logic                         flush_reg;
   logic                         flush_next;
   logic [mie_pkg::DATA_W-1:0]   w_reg;
   logic [mie_pkg::DATA_W-1:0]   w_next;
   logic                         z_reg;
   logic                         z_next;
   mie_pkg::mie_fwr_type         fwr_reg;
   mie_pkg::mie_fwr_type         fwr_next;

   // Execute stage
   mie_pkg::mie_op_type          op;
   logic [mie_pkg::DATA_W-1:0]   res;
   logic [mie_pkg::DATA_W-1:0]   src_data;
   logic [mie_pkg::FADDR_W-1:0]  faddr;
   logic [mie_pkg::PC_W-1:0]     branch_target;
   logic [mie_pkg::DATA_W-1:0]   klit;
   logic                         exec;
   logic                         wr_w;
   logic                         wr_f;
   logic                         z_upd;
   logic                         skip;
   logic                         branch;

   assign prog_addr   = pc_reg;
   assign file_raddr  = raddr_reg;
   assign file_wr     = fwr_reg;
   assign working_out = w_reg;
   assign zero_flag   = z_reg;
   assign skip_cycle  = flush_reg;

   ////////////////////////////////////////////////////////////////////////
   // Operand path
   assign faddr = instr_reg[mie_pkg::FADDR_W-1:0];
   assign klit  = instr_reg[mie_pkg::K8_MSB:0];
   assign exec  = !flush_reg;
   assign branch_target = {
      program_counter_high_latch[mie_pkg::LATCH_MSB:mie_pkg::LATCH_LSB],
      instr_reg[mie_pkg::K11_MSB:0]};

   // File writes land one edge late, so a back-to-back read of the same
   // address takes the pending value instead of the stale one
   assign src_data = (fwr_reg.we && fwr_reg.addr == faddr) ?
                     fwr_reg.data : file_rdata;

   mie_alu u_alu (
      .instr  (instr_reg),
      .w_data (w_reg),
      .f_data (src_data),
      .op     (op),
      .res    (res),
      .wr_w   (wr_w),
      .wr_f   (wr_f),
      .z_upd  (z_upd),
      .skip   (skip),
      .branch (branch)
   );

   ////////////////////////////////////////////////////////////////////////
   // Fetch and execute
   always_comb begin
      pc_next       = pc_reg + 15'h0001;
      instr_next    = prog_data;
      raddr_next    = prog_data[mie_pkg::FADDR_W-1:0];
      flush_next    = 1'b0;
      w_next        = w_reg;
      z_next        = z_reg;
      fwr_next.we   = 1'b0;
      fwr_next.addr = faddr;
      fwr_next.data = res;
      // A flushed slot is a no-operation: it can neither skip nor branch
      if (exec) begin
         if (wr_w) begin
            w_next = res;
         end
         fwr_next.we = wr_f;
         if (z_upd) begin
            z_next = mie_pkg::is_zero(res);
         end
         if (skip) begin
            flush_next = 1'b1;
         end
         if (branch) begin
            pc_next    = branch_target;
            flush_next = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pc_reg    <= mie_pkg::PC_RST;
         instr_reg <= mie_pkg::NOP_WORD;
         raddr_reg <= 7'h00;
         flush_reg <= 1'b0;
         w_reg     <= mie_pkg::W_RST;
         z_reg     <= mie_pkg::Z_RST;
         fwr_reg   <= '0;
      end else begin
         pc_reg    <= pc_next;
         instr_reg <= instr_next;
         raddr_reg <= raddr_next;
         flush_reg <= flush_next;
         w_reg     <= w_next;
         z_reg     <= z_next;
         fwr_reg   <= fwr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   clear_working_a: assert property (
      exec && op == mie_pkg::clear_working_reg_op
      |=> w_reg == 8'h00 && z_reg)
      else $error("working register clear did not zero W and set Z");

   dest_file_a: assert property (
      exec && wr_f
      |=> fwr_reg.we && fwr_reg.addr == $past(faddr)
          && fwr_reg.data == $past(res) && $stable(w_reg))
      else $error("file destination write wrong");

   dest_working_a: assert property (
      exec && wr_w |=> w_reg == $past(res) && !fwr_reg.we)
      else $error("working destination write wrong");

   dec_value_a: assert property (
      exec && op == mie_pkg::decrement_skip_zero_op
      |=> ($past(instr_reg[mie_pkg::DEST_BIT]) ? fwr_reg.data : w_reg)
          == $past(src_data) - 8'h01 && $stable(z_reg))
      else $error("decrement value or flag wrong");

   dec_skip_a: assert property (
      exec && op == mie_pkg::decrement_skip_zero_op && res == 8'h00
      |=> flush_reg ##1 !flush_reg)
      else $error("decrement to zero did not skip one slot");

   dec_noskip_a: assert property (
      exec && op == mie_pkg::decrement_skip_zero_op && res != 8'h00
      |=> !flush_reg)
      else $error("decrement nonzero skipped");

   inc_skip_a: assert property (
      exec && op == mie_pkg::increment_skip_zero_op
      |-> res == src_data + 8'h01
          ##1 $stable(z_reg) && flush_reg == ($past(res) == 8'h00))
      else $error("increment-skip value, flag or skip wrong");

   inc_zero_a: assert property (
      exec && op == mie_pkg::increment_file_op
      |-> res == src_data + 8'h01
          ##1 z_reg == ($past(res) == 8'h00) && !flush_reg)
      else $error("increment zero flag or skip wrong");

   branch_target_a: assert property (
      exec && op == mie_pkg::unconditional_branch_op
      |=> pc_reg == $past(branch_target) && flush_reg ##1 !flush_reg)
      else $error("branch target or two-cycle timing wrong");

   or_literal_a: assert property (
      exec && op == mie_pkg::or_literal_working_op
      |=> w_reg == ($past(w_reg) | $past(klit))
          && z_reg == (w_reg == 8'h00))
      else $error("OR literal result or zero flag wrong");

   // A discarded slot must leave no trace, or a skip would leak effects
   flush_idle_a: assert property (
      flush_reg
      |=> $stable(w_reg) && $stable(z_reg) && !fwr_reg.we && !flush_reg)
      else $error("discarded slot changed core state");

   branch_quiet_a: assert property (
      exec && op == mie_pkg::unconditional_branch_op
      |=> $stable(w_reg) && $stable(z_reg) && !fwr_reg.we)
      else $error("branch changed working register, flag or file");

   inc_value_a: assert property (
      exec && op == mie_pkg::increment_file_op
      && !instr_reg[mie_pkg::DEST_BIT]
      |=> w_reg == $past(src_data) + 8'h01)
      else $error("increment into working register wrong");

endmodule

// [testbench/mie_mem.sv]
`timescale 1ns/100ps
module mie_mem (
   // Clock
   input  wire logic                        sys_clk,
   // Program memory side
   input  wire logic [mie_pkg::PC_W-1:0]    prog_addr,
   output logic [mie_pkg::INSTR_W-1:0]      prog_data,
   // Data register file side
   input  wire logic [mie_pkg::FADDR_W-1:0] file_raddr,
   output logic [mie_pkg::DATA_W-1:0]       file_rdata,
   input  wire mie_pkg::mie_fwr_type        file_wr
);
   logic [mie_pkg::INSTR_W-1:0] prog_mem [0:32767];
   logic [mie_pkg::DATA_W-1:0]  file_mem [0:127];

   // Both reads are combinational, answered in the same cycle
   assign prog_data  = prog_mem[prog_addr];
   assign file_rdata = file_mem[file_raddr];

   always @(posedge sys_clk) begin
      if (file_wr.we === 1'b1) begin
         file_mem[file_wr.addr] <= file_wr.data;
      end
   end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/100ps
module testbench;
   logic                           sys_clk = 1'b0;
   logic                           rst_n = 1'b0;
   logic [mie_pkg::PC_W-1:0]       prog_addr;
   logic [mie_pkg::INSTR_W-1:0]    prog_data;
   logic [mie_pkg::FADDR_W-1:0]    file_raddr;
   logic [mie_pkg::DATA_W-1:0]     file_rdata;
   mie_pkg::mie_fwr_type           file_wr;
   logic [mie_pkg::LATCH_W-1:0]    latch = 7'h00;
   logic [mie_pkg::DATA_W-1:0]     working_out;
   logic                           zero_flag;
   logic                           skip_cycle;
   int                             bad_count = 0;
   int                             check_count = 0;
   int                             cycles = 0;
   int                             skips = 0;

   mie_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .prog_addr(prog_addr),
      .prog_data(prog_data), .file_raddr(file_raddr),
      .file_rdata(file_rdata), .file_wr(file_wr),
      .program_counter_high_latch(latch), .working_out(working_out),
      .zero_flag(zero_flag), .skip_cycle(skip_cycle));
   mie_mem MEM (.sys_clk(sys_clk), .prog_addr(prog_addr),
      .prog_data(prog_data), .file_raddr(file_raddr),
      .file_rdata(file_rdata), .file_wr(file_wr));

   always #25 sys_clk = ~sys_clk;

   // Discarded slots are counted so each scenario after s_clear_or can judge its skips
   always @(posedge sys_clk) begin
      cycles++;
      if (!rst_n) skips = 0;
      else if (skip_cycle === 1'b1) skips++;
      if (cycles >= 20000) begin
         bad_count++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [13:0] fop(logic [5:0] o, logic d, logic [6:0] f);
      return {o, d, f};
   endfunction

   task automatic run(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Holds the core in reset while memories are wiped and reloaded
   task automatic clr;
      @(negedge sys_clk);
      rst_n = 1'b0;
      for (int i = 0; i < 32768; i++) MEM.prog_mem[i] = 14'h0000;
      for (int i = 0; i < 128; i++) MEM.file_mem[i] = 8'h00;
      run(2);
   endtask

   task automatic wz(input logic [7:0] w, input logic z);
      chk("working", {8'h00, w}, {8'h00, working_out});
      chk("zero", {15'h0000, z}, {15'h0000, zero_flag});
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic s_clear_or;
      logic [7:0] ew [4];
      logic       ez [4];
      ew = '{8'h00, 8'h5a, 8'h00, 8'h81};
      ez = '{1'b1, 1'b0, 1'b1, 1'b0};
      clr();
      MEM.prog_mem[0] = 14'h3800;
      MEM.prog_mem[1] = 14'h385a;
      MEM.prog_mem[2] = 14'h0100;
      MEM.prog_mem[3] = 14'h3881;
      rst_n = 1'b1;
      run(1);
      for (int i = 0; i < 4; i++) begin
         run(1);
         wz(ew[i], ez[i]);
      end
   endtask

   task automatic s_inc_file;
      clr();
      MEM.file_mem[5] = 8'hff;
      MEM.prog_mem[0] = fop(6'h0a, 1'b1, 7'h05);
      MEM.prog_mem[1] = fop(6'h0a, 1'b0, 7'h05);
      MEM.prog_mem[2] = 14'h3810;
      rst_n = 1'b1;
      run(2);
      wz(8'h00, 1'b1);
      run(1);
      wz(8'h01, 1'b0);
      run(1);
      wz(8'h11, 1'b0);
      run(2);
      chk("file5", 16'h0000, {8'h00, MEM.file_mem[5]});
      chk("skips", 16'h0000, skips[15:0]);
   endtask

   task automatic s_dec_skip;
      clr();
      MEM.file_mem[9] = 8'h01;
      MEM.file_mem[10] = 8'h02;
      MEM.prog_mem[0] = 14'h3801;
      MEM.prog_mem[1] = fop(6'h0b, 1'b0, 7'h09);
      MEM.prog_mem[2] = 14'h3840;
      MEM.prog_mem[3] = fop(6'h0b, 1'b1, 7'h0a);
      MEM.prog_mem[4] = 14'h3820;
      rst_n = 1'b1;
      run(3);
      wz(8'h00, 1'b0);
      run(4);
      wz(8'h20, 1'b0);
      run(2);
      chk("file10", 16'h0001, {8'h00, MEM.file_mem[10]});
      chk("file9", 16'h0001, {8'h00, MEM.file_mem[9]});
      chk("skips", 16'h0001, skips[15:0]);
   endtask

   task automatic s_inc_skip;
      clr();
      MEM.file_mem[3] = 8'hff;
      MEM.prog_mem[0] = 14'h0100;
      MEM.prog_mem[1] = fop(6'h0f, 1'b1, 7'h03);
      MEM.prog_mem[2] = 14'h3855;
      MEM.prog_mem[3] = fop(6'h0f, 1'b0, 7'h03);
      rst_n = 1'b1;
      run(6);
      wz(8'h01, 1'b1);
      run(2);
      chk("file3", 16'h0000, {8'h00, MEM.file_mem[3]});
      chk("skips", 16'h0001, skips[15:0]);
   endtask

   task automatic s_branch;
      clr();
      latch = 7'h2f;
      MEM.prog_mem[0] = {3'b101, 11'h7ff};
      MEM.prog_mem[1] = 14'h3880;
      MEM.prog_mem[15'h2fff] = 14'h380c;
      rst_n = 1'b1;
      run(2);
      chk("pc", 16'h2fff, {1'b0, prog_addr});
      chk("skip", 16'h0001, {15'h0000, skip_cycle});
      run(2);
      wz(8'h0c, 1'b0);
      chk("skips", 16'h0001, skips[15:0]);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      run(20);
      s_clear_or();
      s_inc_file();
      s_dec_skip();
      s_inc_skip();
      s_branch();
      close_out();
   end
endmodule
